// [rtl/dcb_channel.sv]
// module: one dma channel with burst sizing, item counter and fifo
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module dcb_channel #(
	parameter int FIFO_DEPTH = 8,
	parameter int AW         = 4
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// axi4-lite slave
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// peripheral request lines and burst-end answers
	input  wire logic        src_preq,
	output logic             src_burst_end,
	input  wire logic        dst_preq,
	output logic             dst_burst_end,
	// item port toward the bus master
	output logic             src_rd,
	output logic [2:0]       src_size,
	input  wire logic        src_rd_ack,
	input  wire logic [31:0] src_rd_data,
	output logic             dst_wr,
	output logic [2:0]       dst_size,
	output logic [31:0]      dst_wr_data,
	input  wire logic        dst_wr_ack
);
	localparam int PW = $clog2(FIFO_DEPTH);
	// beats per burst; shift widened so 111 gives 256
	function automatic logic [8:0] beats(input logic [2:0] code);
		beats = (code == 3'h0) ? dcb_pkg::BEATS_ONE :
			dcb_pkg::BEATS_ONE << ({1'b0, code} + 4'h1);
	endfunction : beats
	dcb_pkg::dcb_ctrl_t  ctrl_reg;
	dcb_pkg::dcb_state_t state_reg;
	logic [2:0]          flow_reg;
	logic                done_reg;
	logic [31:0]         fifo_mem [FIFO_DEPTH];
	logic [PW-1:0]       wr_ptr_reg;
	logic [PW-1:0]       rd_ptr_reg;
	logic [PW:0]         fill_reg;
	logic [8:0]          sb_left_reg;
	logic [8:0]          db_left_reg;
	logic [AW-1:0]       awaddr_reg;
	logic [31:0]         wdata_reg;
	logic src_gated;
	logic dst_gated;
	logic push;
	logic pop;
	logic src_issue;
	logic src_take;
	logic dst_take;
	logic finish;
	logic do_write;
	logic start_req;
	logic fields_ok;

	assign src_gated = (flow_reg == dcb_pkg::FLOW_P2M);
	assign dst_gated = (flow_reg == dcb_pkg::FLOW_M2P);
	assign push      = src_rd & src_rd_ack;
	assign src_issue = (state_reg == dcb_pkg::DCB_RUN) & ~src_rd
		& (ctrl_reg.count != 12'h000)
		& (fill_reg < (PW+1)'(FIFO_DEPTH))
		& (~src_gated | (sb_left_reg != dcb_pkg::BEATS_ZERO));
	assign pop = (state_reg == dcb_pkg::DCB_RUN) & (~dst_wr | dst_wr_ack)
		& (fill_reg != '0)
		& (~dst_gated | (db_left_reg != dcb_pkg::BEATS_ZERO));
	// accept a request only between bursts
	assign src_take = src_gated & (state_reg == dcb_pkg::DCB_RUN)
		& src_preq & ~src_burst_end
		& (sb_left_reg == dcb_pkg::BEATS_ZERO)
		& (ctrl_reg.count != 12'h000);
	assign dst_take = dst_gated & (state_reg == dcb_pkg::DCB_RUN)
		& dst_preq & ~dst_burst_end
		& (db_left_reg == dcb_pkg::BEATS_ZERO);
	// done once count is zero and the fifo is empty
	assign finish = (state_reg == dcb_pkg::DCB_RUN)
		& (ctrl_reg.count == 12'h000) & (fill_reg == '0)
		& ~src_rd & (~dst_wr | dst_wr_ack);

	// write performed once address and data are both held
	assign do_write  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign start_req = do_write & (awaddr_reg == dcb_pkg::ADDR_CFG)
		& wdata_reg[dcb_pkg::CFG_START_BIT];
	// reserved widths and flows refuse the start
	assign fields_ok = (ctrl_reg.swidth <= dcb_pkg::WID_MAX)
		& (ctrl_reg.dwidth <= dcb_pkg::WID_MAX)
		& (wdata_reg[dcb_pkg::CFG_FLOW_LSB +: 3] <= dcb_pkg::FLOW_P2M);

	// sizes go out raw, no bus burst encoding is derived
	assign src_size = ctrl_reg.swidth;
	assign dst_size = ctrl_reg.dwidth;

	// write address and data channels, taken in either order
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_reg  <= s_axi_awaddr;
			end else if (do_write) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_reg  <= s_axi_wdata;
			end else if (do_write) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dcb_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_reg == dcb_pkg::ADDR_CTRL ||
			    awaddr_reg == dcb_pkg::ADDR_CFG) begin
				s_axi_bresp <= dcb_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= dcb_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control word; writes ignored while the channel runs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= '0;
		end else if (do_write && awaddr_reg == dcb_pkg::ADDR_CTRL &&
		             state_reg == dcb_pkg::DCB_IDLE) begin
			ctrl_reg <= dcb_pkg::dcb_ctrl_t'(wdata_reg[23:0]);
		end else if (push) begin
			ctrl_reg.count <= ctrl_reg.count - 12'h001;
		end
	end

	// channel state, flow select and sticky done flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= dcb_pkg::DCB_IDLE;
			flow_reg  <= dcb_pkg::FLOW_M2M;
			done_reg  <= 1'b0;
		end else begin
			if (state_reg == dcb_pkg::DCB_IDLE && start_req && fields_ok) begin
				state_reg <= dcb_pkg::DCB_RUN;
				flow_reg  <= wdata_reg[dcb_pkg::CFG_FLOW_LSB +: 3];
			end else if (finish) begin
				state_reg <= dcb_pkg::DCB_IDLE;
			end
			// completion wins over the clear by a new start
			if (finish) begin
				done_reg <= 1'b1;
			end else if (start_req) begin
				done_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sb_left_reg   <= dcb_pkg::BEATS_ZERO;
			db_left_reg   <= dcb_pkg::BEATS_ZERO;
			src_burst_end <= 1'b0;
			dst_burst_end <= 1'b0;
		end else begin
			src_burst_end <= 1'b0;
			dst_burst_end <= 1'b0;
			if (finish) begin
				sb_left_reg <= dcb_pkg::BEATS_ZERO;
			end else if (src_take) begin
				sb_left_reg <= beats(ctrl_reg.sbsize);
			end else if (push && src_gated) begin
				sb_left_reg   <= sb_left_reg - dcb_pkg::BEATS_ONE;
				src_burst_end <= (sb_left_reg == dcb_pkg::BEATS_ONE) |
					(ctrl_reg.count == 12'h001);
			end
			if (finish) begin
				db_left_reg <= dcb_pkg::BEATS_ZERO;
			end else if (dst_take) begin
				db_left_reg <= beats(ctrl_reg.dbsize);
			end else if (pop && dst_gated) begin
				db_left_reg   <= db_left_reg - dcb_pkg::BEATS_ONE;
				dst_burst_end <= (db_left_reg == dcb_pkg::BEATS_ONE);
			end
		end
	end

	// source item request, held until acknowledged
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			src_rd <= 1'b0;
		end else if (src_issue) begin
			src_rd <= 1'b1;
		end else if (src_rd_ack) begin
			src_rd <= 1'b0;
		end
	end

	// destination item write; a pop reloads the data at once
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dst_wr      <= 1'b0;
			dst_wr_data <= 32'h0000_0000;
		end else if (pop) begin
			dst_wr      <= 1'b1;
			dst_wr_data <= fifo_mem[rd_ptr_reg];
		end else if (dst_wr_ack) begin
			dst_wr <= 1'b0;
		end
	end

	// item fifo; depth bounds one outstanding source read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg   <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(FIFO_DEPTH-1)) ? '0 :
					wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(FIFO_DEPTH-1)) ? '0 :
					rd_ptr_reg + PW'(1);
			end
			if (push && !pop) begin
				fill_reg <= fill_reg + (PW+1)'(1);
			end else if (pop && !push) begin
				fill_reg <= fill_reg - (PW+1)'(1);
			end
		end
	end

	// storage has no reset, it is only read after a push
	always_ff @(posedge sys_clk) begin
		if (push) begin
			fifo_mem[wr_ptr_reg] <= src_rd_data;
		end
	end

	// read channel; one read under way at a time
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= dcb_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp  <= dcb_pkg::RESP_OKAY;
			if (s_axi_araddr == dcb_pkg::ADDR_CTRL) begin
				// remaining items, not the programmed value
				s_axi_rdata <= {8'h00, ctrl_reg};
			end else if (s_axi_araddr == dcb_pkg::ADDR_CFG) begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rdata[dcb_pkg::CFG_FLOW_LSB +: 3] <= flow_reg;
				s_axi_rdata[dcb_pkg::CFG_ACT_BIT]  <= (fill_reg != '0);
				s_axi_rdata[dcb_pkg::CFG_DONE_BIT] <= done_reg;
				s_axi_rdata[dcb_pkg::CFG_BUSY_BIT] <= state_reg;
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= dcb_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : dcb_channel

// [rtl/dcb_pkg.sv]
// package: register map, field layout and codes of the dma channel slice
package dcb_pkg;
	// register byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CFG  = 4'h4;

	// control word field positions
	localparam int CNT_LSB = 0;
	localparam int CNT_W   = 12;
	localparam int SBS_LSB = 12;
	localparam int DBS_LSB = 15;
	localparam int SWD_LSB = 18;
	localparam int DWD_LSB = 21;

	// configuration word field positions
	localparam int CFG_START_BIT = 0;
	localparam int CFG_FLOW_LSB  = 11;
	localparam int CFG_ACT_BIT   = 17;
	localparam int CFG_DONE_BIT  = 18;
	localparam int CFG_BUSY_BIT  = 19;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [2:0] WID_MAX = 3'h2; // codes above are reserved
	localparam logic [2:0] FLOW_M2M = 3'h0;
	localparam logic [2:0] FLOW_M2P = 3'h1;
	localparam logic [2:0] FLOW_P2M = 3'h2;

	localparam logic [8:0] BEATS_ONE  = 9'h001;
	localparam logic [8:0] BEATS_ZERO = 9'h000;

	// channel control word as stored
	typedef struct packed {
		logic [2:0]  dwidth;
		logic [2:0]  swidth;
		logic [2:0]  dbsize;
		logic [2:0]  sbsize;
		logic [11:0] count;
	} dcb_ctrl_t;

	typedef enum logic [0:0] {
		DCB_IDLE = 1'b0,
		DCB_RUN  = 1'b1
	} dcb_state_t;
endpackage : dcb_pkg

// [test/dcb_channel_monitor.sv]
// checker: handshake and item-flow properties at the channel ports
`timescale 1ns/1ps
module dcb_monitor (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        src_burst_end,
	input wire logic        src_rd,
	input wire logic [2:0]  src_size,
	input wire logic        src_rd_ack,
	input wire logic        dst_wr,
	input wire logic [31:0] dst_wr_data,
	input wire logic        dst_wr_ack
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_bresp_held: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
	a_read_next: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
	a_rdata_held: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("r changed");
	a_ar_blocked: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
	a_src_held: assert property (
		src_rd && !src_rd_ack |=> src_rd) else $error("src dropped");
	a_src_gap: assert property (
		src_rd && src_rd_ack |=> !src_rd) else $error("src no gap");
	a_dst_held: assert property (
		dst_wr && !dst_wr_ack |=> dst_wr && $stable(dst_wr_data))
		else $error("dst changed");
	a_burst_pulse: assert property (
		src_burst_end |=> !src_burst_end) else $error("burst end long");
	a_size_legal: assert property (
		src_rd |-> src_size <= dcb_pkg::WID_MAX) else $error("bad size");
	c_burst: cover property (src_burst_end);
	c_write: cover property (dst_wr && dst_wr_ack);
	c_bresp: cover property (s_axi_bvalid);
endmodule : dcb_monitor

// [test/dcb_mem_model.sv]
// partner: memory side of the item port, answering lat+1 cycles after a request
`timescale 1ns/1ps
module dcb_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [1:0]  lat,
	input  wire logic [31:0] key,
	input  wire logic        src_rd,
	output logic             src_rd_ack,
	output logic [31:0]      src_rd_data,
	input  wire logic        dst_wr,
	output logic             dst_wr_ack
);
	logic [1:0]  sw, dw;
	logic [31:0] idx;
	// data is scrambled outside the ack cycle so stale reads show up
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{src_rd_ack, dst_wr_ack, sw, dw} <= 6'h0;
			{src_rd_data, idx} <= 64'h0;
		end else begin
			src_rd_ack <= 1'b0;
			dst_wr_ack <= 1'b0;
			src_rd_data <= ~src_rd_data;
			if (src_rd && !src_rd_ack) begin
				sw <= (sw == lat) ? 2'h0 : sw + 2'h1;
				if (sw == lat) begin
					src_rd_ack <= 1'b1;
					src_rd_data <= key ^ idx;
					idx <= idx + 32'h1;
				end
			end
			if (dst_wr && !dst_wr_ack) begin
				dw <= (dw == lat) ? 2'h0 : dw + 2'h1;
				dst_wr_ack <= (dw == lat);
			end
		end
	end
endmodule : dcb_mem_model

// [test/tb_dma_channel_burst_and_count.sv]
// testbench: registers, burst sizing and item flow of one channel
`timescale 1ns/1ps
module tb_dma_channel_burst_and_count;
	logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, src_preq, dst_preq;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, src_burst_end, dst_burst_end, src_rd;
	logic        src_rd_ack, dst_wr, dst_wr_ack;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, lat, rsp;
	logic [2:0]  src_size, dst_size;
	logic [31:0] s_axi_wdata, s_axi_rdata, src_rd_data, dst_wr_data, key;
	logic [31:0] rdv, q[$];
	int          mismatches = 0, comparisons = 0, cyc = 0;
	int          src_n = 0, dst_n = 0, issued = 0;
	integer      seed = 32'h6dba40dd;
	dcb_channel dut (.*);
	dcb_mem_model partner (.*);
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task tally_and_finish;
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task wr(input logic [3:0] a, input logic [31:0] d);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task rd(input logic [3:0] a);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{rdv, rsp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask : rd
	// one transfer; peripheral modes run two full bursts
	task run(input logic [2:0] flow, input logic [2:0] code);
		logic [11:0] cnt;
		logic [2:0]  sw, dw;
		logic [31:0] k;
		int          beats, n0;
		beats = (code == 3'h0) ? 1 : (2 << code);
		k = $random(seed);
		key <= k;
		lat <= 2'($random(seed));
		// counts in fours keep any width pair whole
		cnt = (flow == 3'h0) ? 12'h4 << ($random(seed) & 3) : 12'(2 * beats);
		sw = (flow == 3'h0) ? 3'(($random(seed) & 255) % 3) : 3'h2;
		dw = (flow == 3'h0) ? 3'(($random(seed) & 255) % 3) : 3'h2;
		for (int i = 0; i < cnt; i++) q.push_back(k ^ (issued + i));
		issued += cnt;
		wr(dcb_pkg::ADDR_CTRL, {8'h0, dw, sw, code, code, cnt});
		// width codes reach the item port as written
		check({dst_size, src_size}, {dw, sw});
		// requests held high must not matter here
		if (flow == dcb_pkg::FLOW_M2M) {src_preq, dst_preq} <= 2'h3;
		wr(dcb_pkg::ADDR_CFG, {18'h0, flow, 11'h1});
		for (int b = 0; b < 2 && flow != dcb_pkg::FLOW_M2M; b++) begin
			n0 = (flow == dcb_pkg::FLOW_P2M) ? src_n : dst_n;
			// peripheral raises its request when ready
			{src_preq, dst_preq} <= (flow == dcb_pkg::FLOW_P2M) ? 2'h2 : 2'h1;
			do @(posedge sys_clk);
			while (!(src_burst_end && src_preq || dst_burst_end && dst_preq));
			{src_preq, dst_preq} <= 2'h0;
			// burst end comes with the last write, before its ack
			while (flow == dcb_pkg::FLOW_M2P && dst_wr)
				@(posedge sys_clk);
			check(32'((flow == 3'h2 ? src_n : dst_n) - n0), beats);
			@(posedge sys_clk);
			if (flow == dcb_pkg::FLOW_P2M && b == 0) rd(dcb_pkg::ADDR_CTRL);
			if (flow == dcb_pkg::FLOW_P2M && b == 0) check(rdv[11:0], beats);
		end
		do rd(dcb_pkg::ADDR_CFG);
		while (rdv[dcb_pkg::CFG_BUSY_BIT] !== 1'b0);
		{src_preq, dst_preq} <= 2'h0;
		check({rdv[dcb_pkg::CFG_DONE_BIT], rdv[dcb_pkg::CFG_ACT_BIT]}, 2'h2);
		check(q.size(), 0);
		rd(dcb_pkg::ADDR_CTRL);
		check(rdv[11:0], 0);
	endtask : run
	// scoreboard: each written item against the oldest note; hang guard
	always @(posedge sys_clk) begin
		if (src_rd && src_rd_ack) src_n <= src_n + 1;
		if (dst_wr && dst_wr_ack) begin
			dst_n <= dst_n + 1;
			if (q.size() == 0) check(dst_wr_data, ~dst_wr_data);
			else check(dst_wr_data, q.pop_front());
		end
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	initial begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
		{s_axi_arvalid, s_axi_rready, src_preq, dst_preq} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00f;
		{s_axi_wdata, key, lat} = 66'h0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(dcb_pkg::ADDR_CTRL);
		check(rdv, 0);
		rd(dcb_pkg::ADDR_CFG);
		check(rdv, 0);
		wr(4'h8, 32'h0);
		check(rsp, dcb_pkg::RESP_SLVERR);
		rd(4'hc);
		check(rsp, dcb_pkg::RESP_SLVERR);
		// reserved width, then reserved flow: start must be refused
		for (int i = 0; i < 2; i++) begin
			wr(dcb_pkg::ADDR_CTRL, i ? 32'h00480004 : 32'h00e00004);
			wr(dcb_pkg::ADDR_CFG, i ? 32'h1801 : 32'h1);
			rd(dcb_pkg::ADDR_CFG);
			check(rdv[dcb_pkg::CFG_BUSY_BIT], 1'b0);
		end
		// every burst code on both peripheral sides
		for (int c = 0; c < 8; c++) run(dcb_pkg::FLOW_P2M, 3'(c));
		for (int c = 0; c < 8; c++) run(dcb_pkg::FLOW_M2P, 3'(c));
		repeat (3) run(dcb_pkg::FLOW_M2M, 3'h0);
		tally_and_finish;
	end
endmodule : tb_dma_channel_burst_and_count
bind dcb_channel dcb_monitor mon (.*);
